// File: logic/usp_link_if.sv
// Serial link between the port and its remote peer.
// Assumes both ends idle their line high.
`timescale 1ns/1ps
interface usp_link_if;
  logic serial_tx_out;
  logic serial_rx_in;
  modport dev (output serial_tx_out, input serial_rx_in);
  modport peer (input serial_tx_out, output serial_rx_in);
endinterface

// File: logic/usp_peer.sv
// Remote end of the serial link: plain byte ports on the user side.
// Assumes the same frame options and bit rate as the port it faces.
`timescale 1ns/1ps
module usp_peer import usp_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  usp_link_if.peer link,
  input wire usp_cfg_t cfg,
  input wire logic [15:0] divisor,
  input wire logic tx_wake,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_addr,
  output logic rx_perr,
  output logic rx_ferr,
  output logic rx_brk
);
  logic [15:0] pre_cnt;
  logic tick, s1, s2, prev, line, done;
  usp_ln_t tx_st, rx_st;
  logic [12:0] sh, v;
  logic [3:0] left, idx;
  logic [2:0] tph, rph;
  usp_rx_t dec;

  assign dec = usp_decode(cfg, v);
  assign link.serial_rx_in = line;

  // ==========================================================
  // Bit tick and pin synchroniser.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 16'h0;
      tick <= 1'b0;
      {s1, s2, prev} <= 3'h7;
    end else begin
      s1 <= link.serial_tx_out;
      s2 <= s1;
      prev <= s2;
      tick <= (pre_cnt >= usp_reload(divisor));
      pre_cnt <= (pre_cnt >= usp_reload(divisor)) ? 16'h0 : pre_cnt + 16'h1;
    end
  end

  // ==========================================================
  // Transmitter; ready falls for the whole frame.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st <= USP_IDLE;
      tx_ready <= 1'b1;
      sh <= '1;
      left <= 4'h0;
      tph <= 3'h0;
      line <= 1'b1;
    end else begin
      line <= (tx_st == USP_RUN) ? sh[0] : 1'b1;
      if (tx_ready && tx_valid && tick) begin // Tick-aligned so the start bit is whole.
        sh <= usp_frame(cfg, tx_data, tx_wake);
        left <= usp_nbits(cfg);
        tph <= 3'h0;
        tx_st <= USP_RUN;
        tx_ready <= 1'b0;
      end else if (tx_st == USP_RUN && tick) begin
        tph <= tph + 3'h1;
        if (tph == USP_PH_LAST) begin
          sh <= {1'b1, sh[12:1]};
          left <= left - 4'h1;
          if (left == 4'h1) begin
            tx_st <= USP_IDLE;
            tx_ready <= 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================
  // Receiver; results appear one cycle after the last stop sample.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st <= USP_IDLE;
      v <= '0;
      idx <= 4'h0;
      rph <= 3'h0;
      done <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      {rx_addr, rx_perr, rx_ferr, rx_brk} <= 4'h0;
    end else begin
      done <= 1'b0;
      rx_valid <= done;
      if (done) begin
        rx_data <= dec.data;
        {rx_addr, rx_perr, rx_ferr, rx_brk} <= {dec.addr, dec.perr, dec.ferr, dec.brk};
      end
      if (rx_st == USP_IDLE) begin
        if (prev && !s2) begin
          rx_st <= USP_RUN;
          rph <= 3'h0;
          idx <= 4'h0;
          v <= '0;
        end
      end else if (tick) begin
        rph <= rph + 3'h1;
        if (rph == USP_PH_SAMPLE) begin
          v[idx] <= s2;
          idx <= idx + 4'h1;
          if (idx == 4'h0 && s2) begin
            rx_st <= USP_IDLE;
          end else if (idx == usp_nbits(cfg) - 4'h1) begin
            rx_st <= USP_IDLE;
            done <= 1'b1;
          end
        end
      end
    end
  end

endmodule

// File: logic/usp_pkg.sv
// Shared constants, types and frame helpers for the async serial port.
// Assumes both link ends are built with the same frame options.
package usp_pkg;

  // ==========================================================
  // Register word indices; byte address is four times the index.
  localparam logic [15:0] USP_IDX_COMM = 16'h7050;
  localparam logic [15:0] USP_IDX_CTL1 = 16'h7051;
  localparam logic [15:0] USP_IDX_DIVH = 16'h7052;
  localparam logic [15:0] USP_IDX_DIVL = 16'h7053;
  localparam logic [15:0] USP_IDX_CTL2 = 16'h7054;
  localparam logic [15:0] USP_IDX_RXST = 16'h7055;
  localparam logic [15:0] USP_IDX_RXDBG = 16'h7056;
  localparam logic [15:0] USP_IDX_RXBUF = 16'h7057;
  localparam logic [15:0] USP_IDX_TXBUF = 16'h7059;
  localparam logic [15:0] USP_IDX_FFTX = 16'h705a;
  localparam logic [15:0] USP_IDX_FFRX = 16'h705b;
  localparam logic [15:0] USP_IDX_FFCT = 16'h705c;
  localparam logic [15:0] USP_IDX_PRI = 16'h705f;

  // ==========================================================
  // Values after reset and timing counts.
  localparam logic [7:0] USP_RST_COMM = 8'h07;
  localparam logic [7:0] USP_RST_ZERO = 8'h00;
  localparam logic [2:0] USP_PH_LAST = 3'h7;
  localparam logic [2:0] USP_PH_SAMPLE = 3'h3;
  localparam logic [6:0] USP_IDLE_TICKS = 7'h50;

  // ==========================================================
  // Frame options, laid out as the comm_control register.
  typedef struct packed {
    logic two_stop;
    logic par_odd;
    logic par_en;
    logic spare;
    logic addr_mode;
    logic [2:0] len_m1;
  } usp_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic addr;
    logic perr;
    logic ferr;
    logic brk;
  } usp_rx_t;

  typedef enum logic {USP_IDLE = 1'b0, USP_RUN = 1'b1} usp_ln_t;

  // Prescaler reload; eight ticks make one bit.
  function automatic logic [15:0] usp_reload(logic [15:0] bit_rate_divisor);
    return (bit_rate_divisor == 16'h0000) ? 16'h0001 : bit_rate_divisor;
  endfunction

  // Bits in a frame, start bit included.
  function automatic logic [3:0] usp_nbits(usp_cfg_t c);
    return 4'(c.len_m1) + 4'h3 + 4'(c.addr_mode) + 4'(c.par_en) + 4'(c.two_stop);
  endfunction

  // Frame sent LSB first: start, data, address bit, parity, stops.
  function automatic logic [12:0] usp_frame(usp_cfg_t c, logic [7:0] d, logic w);
    logic [12:0] v;
    logic [3:0] p;
    logic par;
    v = '1;
    v[0] = 1'b0;
    par = c.par_odd;
    for (int i = 0; i < 8; i++) begin
      if (3'(i) <= c.len_m1) begin
        v[i+1] = d[i];
        par = par ^ d[i];
      end
    end
    p = 4'(c.len_m1) + 4'h2;
    if (c.addr_mode) begin
      v[p] = w;
      p = p + 4'h1;
    end
    if (c.par_en) begin
      v[p] = par;
    end
    return v; // Remaining ones are the stop bits.
  endfunction

  // Decode a sampled frame, start bit in bit 0.
  function automatic usp_rx_t usp_decode(usp_cfg_t c, logic [12:0] r);
    usp_rx_t o;
    logic [3:0] p;
    logic par;
    logic [12:0] m;
    o = '0;
    par = c.par_odd;
    for (int i = 0; i < 8; i++) begin
      if (3'(i) <= c.len_m1) begin
        o.data[i] = r[i+1];
        par = par ^ r[i+1];
      end
    end
    p = 4'(c.len_m1) + 4'h2;
    if (c.addr_mode) begin
      o.addr = r[p];
      p = p + 4'h1;
    end
    if (c.par_en) begin
      o.perr = (r[p] != par);
      p = p + 4'h1;
    end
    o.ferr = !r[p] || (c.two_stop && !r[p+4'h1]);
    m = 13'((14'h1 << usp_nbits(c)) - 14'h1);
    o.brk = ((r & m) == 13'h0);
    return o;
  endfunction

endpackage

// File: logic/usp_port.sv
// Async serial port with APB register access and the device end of the link.
// Assumes an APB master on pclk; the serial input is asynchronous.
// What this block does
// - Bit rate is clock over (divisor+1)*8 or 16
// - Divisor is 16 bits in two byte registers
// - One start bit, then one to eight data bits
// - Optional even or odd parity bit
// - One or two stop bits
// - NRZ levels held a full bit period
// - Check break, parity, overrun, framing separately
// - Buffer register ahead of each shift register
// - Separate enable and interrupt enable per direction
// - Transmit and receive run independently, full duplex
// - Idle-line and address-bit wake-up modes
// - Transmit ready flag when buffer accepts data
// - Transmit empty flag when nothing queued or shifting
// - Receive ready flag when character waits
// - Break flag and four-way summary error flag
// - Break has no own enable bit
// - Reads give data low, upper bits zero
// - Upper written bits are ignored
// - Register frame starts at word 7050h
// - Hardware measures incoming bit rate automatically
`timescale 1ns/1ps
module usp_port import usp_pkg::*; #(
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  usp_link_if.dev link
);
  localparam int AW = $clog2(DEPTH);

  logic [7:0] comm_control, control_one, divisor_high, divisor_low, debug_priority;
  logic [1:0] int_en;
  logic fifo_en, ab_en, ab_done;
  logic pe_f, oe_f, fe_f, brk_f, wake_f;
  logic [15:0] pre_cnt;
  logic tick;
  logic rx_s1, rx_s2, rx_prev;
  logic [7:0] tmem [DEPTH];
  logic [7:0] rmem [DEPTH];
  logic [AW-1:0] twp, trp, rwp, rrp;
  logic [AW:0] tcnt, rcnt, cap;
  usp_ln_t tx_st, rx_st;
  logic [12:0] tx_sh, rx_v;
  logic [3:0] tx_left, rx_idx;
  logic [2:0] tx_ph, rx_ph;
  logic tx_line, rx_done, idle_seen;
  logic [6:0] idle_cnt;
  logic ab_meas;
  logic [18:0] ab_cnt;
  usp_cfg_t cfg;
  usp_rx_t dec;
  logic [15:0] widx;
  logic addr_ok, acc, wr, rd, tx_push, tx_load, rx_pop, accept, wake_hit, ab_fin, rd_ok;
  logic [7:0] rd_val;
  logic [15:0] ab_brr;

  // ==========================================================
  // Bus decode.
  assign cfg = usp_cfg_t'(comm_control);
  assign widx = paddr[17:2];
  assign addr_ok = (paddr[31:18] == 14'h0) && (paddr[1:0] == 2'h0);
  assign acc = psel && penable && pready && addr_ok;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign cap = fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1);
  assign tx_push = wr && (widx == USP_IDX_TXBUF) && (tcnt < cap);
  // Loading only on a tick makes the start bit a whole bit time, not one cycle short.
  assign tx_load = (tx_st == USP_IDLE) && control_one[1] && (tcnt != '0) && tick;
  assign rx_pop = rd && (widx == USP_IDX_RXBUF) && (rcnt != '0);
  assign dec = usp_decode(cfg, rx_v);
  assign wake_hit = cfg.addr_mode ? dec.addr : idle_seen;
  assign accept = rx_done && (!control_one[2] || wake_hit);
  assign ab_fin = ab_meas && rx_s2;
  assign ab_brr = (ab_cnt[18:3] == 16'h0) ? 16'h0 : ab_cnt[18:3] - 16'h1;
  assign link.serial_tx_out = tx_line;

  // Read mux; bits above 7 always read zero.
  always_comb begin
    rd_ok = 1'b1;
    rd_val = 8'h00;
    case (widx)
      USP_IDX_COMM: rd_val = comm_control;
      USP_IDX_CTL1: rd_val = control_one;
      USP_IDX_DIVH: rd_val = divisor_high;
      USP_IDX_DIVL: rd_val = divisor_low;
      USP_IDX_CTL2: rd_val = {tcnt < cap, (tx_st == USP_IDLE) && (tcnt == '0), 4'h0, int_en};
      USP_IDX_RXST: rd_val = {pe_f | oe_f | fe_f | brk_f, rcnt != '0, brk_f, fe_f, oe_f, pe_f, wake_f, 1'b0};
      USP_IDX_RXDBG: rd_val = rmem[rrp];
      USP_IDX_RXBUF: rd_val = rmem[rrp];
      USP_IDX_TXBUF: rd_val = 8'h00;
      USP_IDX_FFTX: rd_val = {fifo_en, 7'(tcnt)};
      USP_IDX_FFRX: rd_val = 8'(rcnt);
      USP_IDX_FFCT: rd_val = {ab_done, 6'h00, ab_en};
      USP_IDX_PRI: rd_val = debug_priority;
      default: rd_ok = 1'b0;
    endcase
    if (!addr_ok) begin
      rd_ok = 1'b0;
    end
  end

  // ==========================================================
  // APB answer: no wait state; the read data comes from a flop loaded in the setup phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        prdata <= {24'h0, rd_val};
        pslverr <= !rd_ok;
      end
    end
  end

  // Software registers; the bit-rate search overrides the divisor when it ends.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comm_control <= USP_RST_COMM;
      control_one <= USP_RST_ZERO;
      divisor_high <= USP_RST_ZERO;
      divisor_low <= USP_RST_ZERO;
      debug_priority <= USP_RST_ZERO;
      int_en <= 2'h0;
      fifo_en <= 1'b0;
      ab_en <= 1'b0;
      ab_done <= 1'b0;
    end else begin
      if (wr) begin
        case (widx)
          USP_IDX_COMM: comm_control <= pwdata[7:0];
          USP_IDX_CTL1: control_one <= pwdata[7:0];
          USP_IDX_DIVH: divisor_high <= pwdata[7:0];
          USP_IDX_DIVL: divisor_low <= pwdata[7:0];
          USP_IDX_CTL2: int_en <= pwdata[1:0];
          USP_IDX_FFTX: fifo_en <= pwdata[7];
          USP_IDX_FFCT: begin
            ab_en <= pwdata[0];
            ab_done <= ab_done && !pwdata[0];
          end
          USP_IDX_PRI: debug_priority <= pwdata[7:0];
          default: ;
        endcase
      end
      if (ab_fin) begin
        {divisor_high, divisor_low} <= ab_brr;
        ab_en <= 1'b0;
        ab_done <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Bit tick: eight per bit at pclk/(reload+1).
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 16'h0;
      tick <= 1'b0;
    end else if (pre_cnt >= usp_reload({divisor_high, divisor_low})) begin
      pre_cnt <= 16'h0;
      tick <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 16'h1;
      tick <= 1'b0;
    end
  end

  // Pin synchroniser; the second stage is sampled, the third only joins it to find the falling edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_s1 <= link.serial_rx_in;
      rx_s2 <= rx_s1;
      rx_prev <= rx_s2;
    end
  end

  // ==========================================================
  // Transmit queue; depth one when queueing is off gives the plain buffer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      twp <= '0;
      trp <= '0;
      tcnt <= '0;
    end else begin
      if (tx_push) begin
        tmem[twp] <= pwdata[7:0];
        twp <= twp + 1'b1;
      end
      if (tx_load) begin
        trp <= trp + 1'b1;
      end
      tcnt <= tcnt + (AW+1)'(tx_push) - (AW+1)'(tx_load);
    end
  end

  // Transmit shifter; a frame once begun completes even if disabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st <= USP_IDLE;
      tx_sh <= '1;
      tx_left <= 4'h0;
      tx_ph <= 3'h0;
      tx_line <= 1'b1;
    end else begin
      tx_line <= (tx_st == USP_RUN) ? tx_sh[0] : 1'b1;
      if (tx_load) begin
        tx_sh <= usp_frame(cfg, tmem[trp], control_one[3]);
        tx_left <= usp_nbits(cfg);
        tx_ph <= 3'h0;
        tx_st <= USP_RUN;
      end else if (tx_st == USP_RUN && tick) begin
        tx_ph <= tx_ph + 3'h1;
        if (tx_ph == USP_PH_LAST) begin
          tx_sh <= {1'b1, tx_sh[12:1]};
          tx_left <= tx_left - 4'h1;
          if (tx_left == 4'h1) begin
            tx_st <= USP_IDLE;
          end
        end
      end
    end
  end

  // ==========================================================
  // Receive sampler; runs apart from the transmitter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st <= USP_IDLE;
      rx_v <= '0;
      rx_idx <= 4'h0;
      rx_ph <= 3'h0;
      rx_done <= 1'b0;
      idle_cnt <= 7'h0;
      idle_seen <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (rx_st == USP_IDLE) begin
        if (!rx_s2) begin
          idle_cnt <= 7'h0;
        end else if (tick && idle_cnt != USP_IDLE_TICKS) begin
          idle_cnt <= idle_cnt + 7'h1;
        end
        if (rx_prev && !rx_s2 && control_one[0] && !ab_en) begin
          rx_st <= USP_RUN;
          rx_ph <= 3'h0;
          rx_idx <= 4'h0;
          rx_v <= '0;
          idle_seen <= (idle_cnt == USP_IDLE_TICKS);
        end
      end else if (tick) begin
        rx_ph <= rx_ph + 3'h1;
        if (rx_ph == USP_PH_SAMPLE) begin
          rx_v[rx_idx] <= rx_s2;
          rx_idx <= rx_idx + 4'h1;
          if (rx_idx == 4'h0 && rx_s2) begin
            rx_st <= USP_IDLE;
          end else if (rx_idx == usp_nbits(cfg) - 4'h1) begin
            rx_st <= USP_IDLE;
            rx_done <= 1'b1;
          end
        end
      end
    end
  end

  // Receive queue; a full queue drops the new character as an overrun.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rwp <= '0;
      rrp <= '0;
      rcnt <= '0;
    end else begin
      if (accept && rcnt < cap) begin
        rmem[rwp] <= dec.data;
        rwp <= rwp + 1'b1;
      end
      if (rx_pop) begin
        rrp <= rrp + 1'b1;
      end
      rcnt <= rcnt + (AW+1)'(accept && rcnt < cap) - (AW+1)'(rx_pop);
    end
  end

  // Error flags clear on a buffer read; a new event in that cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pe_f, oe_f, fe_f, brk_f, wake_f} <= 5'h0;
    end else begin
      logic clr;
      clr = rd && (widx == USP_IDX_RXBUF);
      pe_f <= (pe_f && !clr) || (accept && dec.perr);
      oe_f <= (oe_f && !clr) || (accept && rcnt >= cap);
      fe_f <= (fe_f && !clr) || (accept && dec.ferr);
      brk_f <= (brk_f && !clr) || (rx_done && dec.brk);
      wake_f <= (wake_f && !clr) || (accept && wake_hit);
    end
  end

  // Bit-rate search: width of the first low pulse is one bit time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ab_meas <= 1'b0;
      ab_cnt <= 19'h0;
    end else if (!ab_meas) begin
      if (ab_en && rx_prev && !rx_s2) begin
        ab_meas <= 1'b1;
        ab_cnt <= 19'h1;
      end
    end else if (rx_s2) begin
      ab_meas <= 1'b0;
    end else if (ab_cnt != '1) begin
      ab_cnt <= ab_cnt + 19'h1;
    end
  end

endmodule

// File: sim/async_serial_port_tb.sv
// Bench for the serial port facing its peer across one link.
// Assumes the logic files are compiled first; both ends run 16 clocks a bit.
`timescale 1ns/1ps
module async_serial_port_tb import usp_pkg::*;;
  // ==========================================================
  // Signals
  localparam logic [31:0] FM = 32'hffffffff;
  localparam logic [7:0] CFG_TBL[8] = '{8'h07, 8'ha6, 8'h65, 8'h00, 8'h0b, 8'he7, 8'h2f, 8'h42};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  usp_cfg_t pcfg = usp_cfg_t'(8'h07);
  logic [15:0] pdiv = 16'h0;
  logic [7:0] ptx = 8'h0;
  logic pvalid = 1'b0;
  logic ptx_ready, prx_valid, prx_addr, prx_perr, prx_ferr, prx_brk;
  logic [7:0] prx_data;
  logic [31:0] seed = 32'd69162;
  int failures = 0;
  int n_compared = 0;
  logic [32:0] rexp[$];
  logic [32:0] rmsk[$];
  logic [11:0] pq[$];

  // Free-running 200 MHz clock.
  always #2.5 pclk = ~pclk;

  usp_link_if lnk();
  usp_port #(.DEPTH(4)) i_usp_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(lnk.dev));
  usp_peer i_usp_peer (.pclk(pclk), .presetn(presetn), .link(lnk.peer), .cfg(pcfg), .divisor(pdiv),
    .tx_wake(1'b1), .tx_data(ptx), .tx_valid(pvalid), .tx_ready(ptx_ready), .rx_data(prx_data),
    .rx_valid(prx_valid), .rx_addr(prx_addr), .rx_perr(prx_perr), .rx_ferr(prx_ferr), .rx_brk(prx_brk));
  usp_monitor #(.BIT_CYC(16)) i_usp_monitor (.pclk(pclk), .presetn(presetn),
    .serial_tx_out(lnk.serial_tx_out), .serial_rx_in(lnk.serial_rx_in));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Data bits beyond the programmed length arrive as zeros.
  function automatic logic [7:0] lmask(logic [7:0] c);
    return 8'((9'h2 << c[2:0]) - 9'h1);
  endfunction

  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input logic [32:0] msk);
    n_compared++;
    if ((got & msk) !== (exp & msk)) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got & msk, exp & msk);
    end
  endtask

  task automatic final_report();
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {14'h0, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input logic [31:0] msk);
    rexp.push_back({1'b0, exp});
    rmsk.push_back({1'b1, msk});
    apb(1'b0, idx, 32'h0);
  endtask

  // The peer takes a character when valid meets ready, then sends it whole.
  task automatic peer_send(input logic [7:0] d);
    int n;
    @(posedge pclk);
    ptx <= d;
    pvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (ptx_ready !== 1'b0 && n < 50);
    if (ptx_ready !== 1'b0) failures++;
    pvalid <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (ptx_ready !== 1'b1 && n < 400);
    if (ptx_ready !== 1'b1) failures++;
  endtask

  // Waits for the peer to take every noted character, then for the stop bit.
  task automatic wait_q();
    for (int n = 0; n < 3000 && pq.size() != 0; n++) @(posedge pclk);
    if (pq.size() != 0) failures++;
    repeat (16) @(posedge pclk);
  endtask

  task automatic dev_send(input logic [7:0] d, input logic [7:0] c);
    pq.push_back({c[3], 3'b000, d & lmask(c)});
    wr(USP_IDX_TXBUF, {xs() >> 8, d});
  endtask

  // Peer frames differ from the receiver's options or overrun its buffer, so errors must be flagged.
  task automatic err_case(input logic [7:0] dc, input logic [7:0] pc, input int n, input logic [7:0] st);
    logic [7:0] d0;
    d0 = (8'(xs()) & 8'h7f) | 8'h01;
    wr(USP_IDX_COMM, {24'h0, dc});
    pcfg <= usp_cfg_t'(pc);
    peer_send(d0);
    for (int i = 1; i < n; i++) peer_send(8'(xs()) & 8'h7f);
    rd(USP_IDX_RXST, {24'h0, st}, 32'hfd);
    rd(USP_IDX_RXDBG, {24'h0, d0 & lmask(dc)}, FM);
    rd(USP_IDX_RXBUF, {24'h0, d0 & lmask(dc)}, FM);
    rd(USP_IDX_RXST, 32'h0, 32'hfd);
  endtask

  // ==========================================================
  // Watchers: the oldest note is compared whenever a result appears.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && rexp.size() != 0) begin
      chk({pslverr, prdata}, rexp.pop_front(), rmsk.pop_front());
    end
  end

  always @(posedge pclk) begin
    if (prx_valid === 1'b1) begin
      chk(33'({prx_addr, prx_perr, prx_ferr, prx_brk, prx_data}),
        (pq.size() == 0) ? 33'h1000 : 33'(pq.pop_front()), 33'h1fff);
    end
  end

  // Cuts a hang short well beyond the expected run time.
  initial begin
    #(5 * 60000);
    failures++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] d;
    logic [7:0] e;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(USP_IDX_COMM, 32'h07, FM);
    rd(USP_IDX_CTL1, 32'h00, FM);
    rd(USP_IDX_CTL2, 32'hc0, FM);
    rd(USP_IDX_RXST, 32'h00, FM);
    rd(USP_IDX_PRI, 32'h00, FM);
    rexp.push_back(33'h100000000);
    rmsk.push_back(33'h100000000);
    apb(1'b0, 16'h7058, 32'h0);
    wr(USP_IDX_PRI, 32'habcdef5a);
    rd(USP_IDX_PRI, 32'h5a, FM);
    wr(USP_IDX_DIVH, 32'h12345601);
    wr(USP_IDX_DIVL, 32'hffffff77);
    rd(USP_IDX_DIVH, 32'h01, FM);
    rd(USP_IDX_DIVL, 32'h77, FM);
    wr(USP_IDX_DIVH, 32'h0);
    wr(USP_IDX_CTL1, 32'h0b);
    for (int i = 0; i < 8; i++) begin
      wr(USP_IDX_DIVL, 32'(i % 2));
      pdiv <= 16'(i % 2);
      wr(USP_IDX_COMM, {24'h0, CFG_TBL[i]});
      pcfg <= usp_cfg_t'(CFG_TBL[i]);
      d = 8'(xs());
      e = 8'(xs());
      dev_send(d, CFG_TBL[i]);
      peer_send(e);
      wait_q();
      rd(USP_IDX_RXST, 32'h40, 32'hfd);
      rd(USP_IDX_RXBUF, {24'h0, e & lmask(CFG_TBL[i])}, FM);
    end
    err_case(8'h27, 8'h67, 1, 8'hc4);
    err_case(8'h06, 8'h07, 1, 8'hd0);
    err_case(8'h07, 8'h07, 2, 8'hc8);
    pcfg <= usp_cfg_t'(8'h07);
    wr(USP_IDX_CTL1, 32'h09);
    wr(USP_IDX_FFTX, 32'h80);
    for (int i = 0; i < 5; i++) begin
      d = 8'(xs());
      if (i < 4) pq.push_back({4'h0, d});
      wr(USP_IDX_TXBUF, {24'h0, d});
    end
    rd(USP_IDX_FFTX, 32'h84, FM);
    rd(USP_IDX_CTL2, 32'h00, 32'hc0);
    wr(USP_IDX_CTL1, 32'h0b);
    wait_q();
    rd(USP_IDX_CTL2, 32'hc0, 32'hc0);
    final_report();
  end
endmodule

// File: sim/usp_monitor.sv
// Checker for the serial link that joins the port and its peer.
// Assumes both lines idle high and use one bit time of BIT_CYC clocks.
`timescale 1ns/1ps
module usp_monitor #(
  parameter int BIT_CYC = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic serial_tx_out,
  input wire logic serial_rx_in
);
  // ==========================================================
  // Run lengths
  localparam int LOW_MAX = 11 * BIT_CYC;
  logic [7:0] tx_run;
  logic [7:0] rx_run;
  logic tx_q;
  logic rx_q;

  // Reset counts as a long idle, so a frame may start right after release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_q <= 1'b1;
      tx_run <= 8'hff;
    end else begin
      tx_q <= serial_tx_out;
      tx_run <= (serial_tx_out != tx_q) ? 8'h01 : ((tx_run == 8'hff) ? tx_run : tx_run + 8'h01);
    end
  end

  // Same counter for the line that the peer drives.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q <= 1'b1;
      rx_run <= 8'hff;
    end else begin
      rx_q <= serial_rx_in;
      rx_run <= (serial_rx_in != rx_q) ? 8'h01 : ((rx_run == 8'hff) ? rx_run : rx_run + 8'h01);
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  reset_idle_a: assert property ($rose(presetn) |-> serial_tx_out && serial_rx_in)
    else $error("link not idle after reset.");
  tx_low_run_a: assert property ($rose(serial_tx_out) |-> (tx_run % BIT_CYC) == 0)
    else $error("transmit low run not whole bits.");
  rx_low_run_a: assert property ($rose(serial_rx_in) |-> (rx_run % BIT_CYC) == 0)
    else $error("receive low run not whole bits.");
  tx_low_max_a: assert property (!serial_tx_out && !tx_q |-> tx_run < LOW_MAX)
    else $error("transmit line low too long.");
  rx_low_max_a: assert property (!serial_rx_in && !rx_q |-> rx_run < LOW_MAX)
    else $error("receive line low too long.");
  tx_stop_len_a: assert property ($fell(serial_tx_out) |-> tx_run >= BIT_CYC)
    else $error("transmit stop bit too short.");
  rx_stop_len_a: assert property ($fell(serial_rx_in) |-> rx_run >= BIT_CYC)
    else $error("receive stop bit too short.");
  tx_start_mid_a: assert property ($fell(serial_tx_out) |-> ##8 !serial_tx_out)
    else $error("transmit start bit broken.");
  rx_start_mid_a: assert property ($fell(serial_rx_in) |-> ##8 !serial_rx_in)
    else $error("receive start bit broken.");
endmodule
